// [emii_regs.svh]
// register offsets, field positions and reset values of the mii pin block
`ifndef EMII_REGS_SVH
`define EMII_REGS_SVH
`define EMII_OFS_CTRL 8'h00
`define EMII_OFS_STAT 8'h04
`define EMII_OFS_TXDATA 8'h08
`define EMII_OFS_RXDATA 8'h0c
`define EMII_OFS_MGTX 8'h10
`define EMII_OFS_MGRX 8'h14
`define EMII_CB_SERIAL 0
`define EMII_CB_LOOP 1
`define EMII_CB_ALTV 2
`define EMII_CB_PAIR 3
`define EMII_CB_MPS0 4
`define EMII_CB_MPS1 5
`define EMII_CB_PDN 6
`define EMII_CB_LNKDIS 7
`define EMII_CB_TXERR 8
`define EMII_CB_DIV 12
`define EMII_CTRL_RST 16'h0000
`define EMII_SB_TXRDY 0
`define EMII_SB_RXVAL 1
`define EMII_SB_RXOVR 2
`define EMII_SB_RXERR 3
`define EMII_SB_COL 4
`define EMII_SB_CRS 5
`define EMII_SB_MGBUSY 6
`define EMII_SB_GP_RXDV 10
`define EMII_SB_GP_RXER 11
`define EMII_SB_GP_RXD3 12
`define EMII_SB_GP_RXD1 13
`define EMII_SB_TXD1_PIN 14
`define EMII_SB_GP_RXD2 15
`define EMII_MG_OP 29
`define EMII_MG_OP_RD 2'h2
`define EMII_MG_RD_DRIVE 6'h0e
`define EMII_MG_FRAME 6'h20
`define EMII_SER_LAST 3'h7
`define EMII_MII_LAST 3'h1
`endif

// [emii_pkg.sv]
// types shared by the mii pin block
`default_nettype none
package emii_pkg;
  typedef enum logic [1:0] {TX_IDLE = 2'h1, TX_SEND = 2'h2} emii_tx_type;
  typedef enum logic [2:0] {MG_IDLE = 3'h1, MG_DRIVE = 3'h2, MG_LISTEN = 3'h4} emii_mg_type;
  typedef struct packed {
    logic [4:0] cnt;
    logic mdc;
  } emii_mdc_state_type;
  typedef struct packed {
    logic [11:0] s1;
    logic [11:0] s2;
    logic [11:0] s3;
    logic [11:0] f;
    logic [15:0] ctrl;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic rd_pend;
    logic [7:0] rd_addr;
    logic [31:0] hrdata;
    emii_tx_type tx;
    logic [7:0] tx_buf;
    logic tx_full;
    logic [7:0] tx_sh;
    logic [2:0] tx_cnt;
    logic [3:0] txd;
    logic txen;
    logic txer;
    logic [7:0] rx_sh;
    logic [2:0] rx_cnt;
    logic [7:0] rx_byte;
    logic rx_val;
    logic rx_ovr;
    logic rx_err;
    logic [5:0] gp;
    emii_mg_type mg;
    logic [31:0] mg_sh;
    logic [5:0] mg_cnt;
    logic mg_rd;
    logic mdo;
    logic mdo_en;
    logic [15:0] mg_rx;
  } emii_state_type;
endpackage
`default_nettype wire

// [emii_mdc_if.sv]
// link between the pin block and its management clock divider
`default_nettype none
interface emii_mdc_if;
  logic [3:0] div;
  logic run;
  logic mdc;
  logic rise;
  logic fall;
  modport gen (input div, input run, output mdc, output rise, output fall);
  modport user (output div, output run, input mdc, input rise, input fall);
endinterface
`default_nettype wire

// [emii_mdc_gen.sv]
// management clock divider: mdc period is 4*(div+1) system clocks
`default_nettype none
module emii_mdc_gen
  import emii_pkg::*;
(
  input wire logic hclk, // system clock
  input wire logic hresetn, // async reset, active low
  input wire logic ce, // clock enable
  emii_mdc_if.gen m // divider control and clock out
);
  emii_mdc_state_type st;
  emii_mdc_state_type next_st;
  logic wrap;

  assign wrap = m.run && (st.cnt == {m.div, 1'b1});
  assign m.mdc = st.mdc;
  assign m.rise = wrap && !st.mdc;
  assign m.fall = wrap && st.mdc;

  always_comb
  begin
    next_st = st;
    if (!m.run)
    begin
      // idle clock parks low so a frame always opens on a rising edge
      next_st.cnt = 5'h00;
      next_st.mdc = 1'b0;
    end
    else if (wrap)
    begin
      next_st.cnt = 5'h00;
      next_st.mdc = !st.mdc;
    end
    else
    begin
      next_st.cnt = 5'(st.cnt + 5'h01);
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st <= '0;
    end
    else if (ce)
    begin
      st <= next_st;
    end
  end
endmodule
`default_nettype wire

// [emii_pins.sv]
// ethernet mii / serial codec pin interface with ahb-lite registers
// Functional notes
// (RULE_01) serial mode: mdc pin is loopback xor alt-vendor
// (RULE_02) serial mode: mdio pin shows pair type
// (RULE_03) serial mode: txd3/txd2 show media port bits
// (RULE_04) serial mode: txd1 open collector, inverted power-down
// (RULE_05) serial mode: txer pin shows link disable
// (RULE_06) serial mode: rxd3/2/1 read in status 12/15/13
// (RULE_07) serial mode: rxer bit 11, rxdv bit 10
// (RULE_08) gp outputs from control, inputs into status
// (RULE_09) serial mode: transmit bits on txd0 only
// (RULE_10) serial mode: receive bits from rxd0 only
// (RULE_11) mdc divided from system clock by divider
// (RULE_12) mdio driven only in own frame part
// (RULE_13) mii transmit nibble changes on txclk
// (RULE_14) tx enable exactly while data is valid
// (RULE_15) tx error flags errored transmit stream
// (RULE_16) phy raises col during collisions
// (RULE_17) phy raises crs when medium busy
// (RULE_18) receive sampled on phy receive clock
// (RULE_19) phy raises rxer on invalid symbols
// (RULE_20) receive nibbles accepted only with rxdv
// (RULE_21) control bit selects mii or serial mode
`include "emii_regs.svh"
`default_nettype none
module emii_pins
  import emii_pkg::*;
(
  input wire logic hclk, // system clock, 100 MHz
  input wire logic hresetn, // async reset, active low
  input wire logic ce, // clock enable, freezes all state
  input wire logic hsel, // ahb slave select
  input wire logic [31:0] haddr, // ahb address
  input wire logic [1:0] htrans, // ahb transfer type
  input wire logic hwrite, // ahb write
  input wire logic [2:0] hsize, // ahb size
  input wire logic [31:0] hwdata, // ahb write data
  input wire logic hready, // ahb bus ready
  output logic hreadyout, // ahb slave ready
  output logic [31:0] hrdata, // ahb read data
  output logic hresp, // ahb response, always okay
  output logic mdc, // management clock pin
  input wire logic mdio_in, // mdio pin level
  output logic mdio_out, // mdio drive value
  output logic mdio_oe_n, // mdio drive enable, low drives
  input wire logic txclk, // transmit clock from phy
  output logic txd3, // transmit data 3
  output logic txd2, // transmit data 2
  input wire logic txd1_in, // txd1 pin level
  output logic txd1_out, // txd1 drive value
  output logic txd1_oe_n, // txd1 drive enable, low drives
  output logic txd0, // transmit data 0
  output logic txer, // transmit error
  output logic txen, // transmit enable
  input wire logic col, // collision
  input wire logic crs, // carrier sense
  input wire logic rxclk, // receive clock from phy
  input wire logic [3:0] rxd, // receive data
  input wire logic rxer, // receive error
  input wire logic rxdv // receive data valid
);
  // synchroniser slots
  localparam int I_RXDV = 4;
  localparam int I_RXER = 5;
  localparam int I_COL = 6;
  localparam int I_CRS = 7;
  localparam int I_TXCLK = 8;
  localparam int I_RXCLK = 9;
  localparam int I_MDIO = 10;
  localparam int I_TXD1 = 11;

  emii_state_type st;
  emii_state_type next_st;
  emii_mdc_if mi ();
  logic [11:0] fn;
  logic serial;
  logic tx_edge;
  logic rx_edge;
  logic take;
  logic rx_ok;
  logic rx_last;
  logic loaded;

  emii_mdc_gen u_mdc (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .m(mi.gen)
  );

  function automatic logic [31:0] rd_word(input emii_state_type s, input logic [7:0] a);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (a)
      `EMII_OFS_CTRL: w[15:0] = s.ctrl;
      `EMII_OFS_STAT:
      begin
        w[`EMII_SB_TXRDY] = !s.tx_full;
        w[`EMII_SB_RXVAL] = s.rx_val;
        w[`EMII_SB_RXOVR] = s.rx_ovr;
        w[`EMII_SB_RXERR] = s.rx_err;
        w[`EMII_SB_COL] = s.f[I_COL];
        w[`EMII_SB_CRS] = s.f[I_CRS];
        w[`EMII_SB_MGBUSY] = (s.mg != MG_IDLE);
        w[`EMII_SB_GP_RXDV] = s.gp[0]; // [RULE_07]
        w[`EMII_SB_GP_RXER] = s.gp[1]; // [RULE_07]
        w[`EMII_SB_GP_RXD3] = s.gp[2]; // [RULE_06]
        w[`EMII_SB_GP_RXD1] = s.gp[3]; // [RULE_06]
        w[`EMII_SB_TXD1_PIN] = s.gp[5];
        w[`EMII_SB_GP_RXD2] = s.gp[4]; // [RULE_06]
      end
      `EMII_OFS_TXDATA: w[8:0] = {s.tx_full, s.tx_buf};
      `EMII_OFS_RXDATA: w[7:0] = s.rx_byte;
      `EMII_OFS_MGTX: w = s.mg_sh;
      `EMII_OFS_MGRX: w[15:0] = s.mg_rx;
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  assign serial = st.ctrl[`EMII_CB_SERIAL]; // [RULE_21]
  // only the agreed stages 2 and 3 move the filtered value
  assign fn = (st.s3 & ~(st.s2 ^ st.s3)) | (st.f & (st.s2 ^ st.s3));
  assign tx_edge = fn[I_TXCLK] && !st.f[I_TXCLK]; // [RULE_13]
  assign rx_edge = fn[I_RXCLK] && !st.f[I_RXCLK]; // [RULE_18]
  assign take = hsel && hready && htrans[1];
  // serial codec frames on carrier, mii on data valid
  assign rx_ok = serial ? fn[I_CRS] : fn[I_RXDV]; // [RULE_20]
  assign rx_last = (st.rx_cnt == (serial ? `EMII_SER_LAST : `EMII_MII_LAST));
  assign loaded = tx_edge && st.tx_full && (st.tx == TX_IDLE || st.tx_cnt == 3'h0);

  assign mi.div = st.ctrl[`EMII_CB_DIV +: 4];
  assign mi.run = (st.mg != MG_IDLE);

  assign hreadyout = !st.rd_pend;
  assign hrdata = st.hrdata;
  assign hresp = 1'b0;
  // pin muxes between mii function and serial-mode general purpose use
  assign mdc = serial ? (st.ctrl[`EMII_CB_LOOP] ^ st.ctrl[`EMII_CB_ALTV])
                      : mi.mdc; // [RULE_01] [RULE_11]
  assign mdio_out = serial ? st.ctrl[`EMII_CB_PAIR] : st.mdo; // [RULE_02]
  assign mdio_oe_n = serial ? 1'b0 : !st.mdo_en; // [RULE_02] [RULE_12]
  assign txd3 = serial ? st.ctrl[`EMII_CB_MPS0] : st.txd[3]; // [RULE_03]
  assign txd2 = serial ? st.ctrl[`EMII_CB_MPS1] : st.txd[2]; // [RULE_03]
  // serial mode open collector: only ever pulls low, high comes from the board; mii mode drives both levels
  assign txd1_out = serial ? 1'b0 : st.txd[1]; // [RULE_04]
  assign txd1_oe_n = serial ? !st.ctrl[`EMII_CB_PDN] : 1'b0; // [RULE_04]
  assign txd0 = st.txd[0]; // [RULE_09]
  assign txer = serial ? st.ctrl[`EMII_CB_LNKDIS] : st.txer; // [RULE_05] [RULE_15]
  assign txen = st.txen; // [RULE_14]

  always_comb
  begin
    next_st = st;
    next_st.s1 = {txd1_in, mdio_in, rxclk, txclk, crs, col, rxer, rxdv, rxd};
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.f = fn;
    // status register takes the pin levels every cycle
    next_st.gp = {fn[I_TXD1], fn[2], fn[1], fn[3], fn[I_RXER], fn[I_RXDV]}; // [RULE_08]

    // bus slave: writes commit in the data phase, reads wait one cycle
    next_st.wr_pend = take && hwrite && (hsize == 3'h2);
    next_st.wr_addr = haddr[7:0];
    next_st.rd_pend = take && !hwrite;
    if (take && !hwrite)
    begin
      next_st.rd_addr = haddr[7:0];
    end
    if (st.rd_pend)
    begin
      next_st.hrdata = rd_word(st, st.rd_addr);
      if (st.rd_addr == `EMII_OFS_RXDATA)
      begin
        next_st.rx_val = 1'b0;
      end
      if (st.rd_addr == `EMII_OFS_STAT)
      begin
        next_st.rx_ovr = 1'b0;
        next_st.rx_err = 1'b0;
      end
    end

    // transmit: one byte, low nibble or lsb first
    if (tx_edge)
    begin
      case (st.tx)
        TX_IDLE:
        begin
          if (st.tx_full)
          begin
            next_st.tx = TX_SEND;
          end
        end
        TX_SEND:
        begin
          if (st.tx_cnt != 3'h0)
          begin
            next_st.tx_cnt = 3'(st.tx_cnt - 3'h1);
            if (serial)
            begin
              next_st.txd = {3'h0, st.tx_sh[0]}; // [RULE_09]
              next_st.tx_sh = {1'b0, st.tx_sh[7:1]};
            end
            else
            begin
              next_st.txd = st.tx_sh[3:0]; // [RULE_13]
              next_st.tx_sh = {4'h0, st.tx_sh[7:4]};
            end
          end
          else if (!st.tx_full)
          begin
            next_st.tx = TX_IDLE;
            next_st.txen = 1'b0; // [RULE_14]
            next_st.txd = 4'h0;
            next_st.txer = 1'b0;
          end
        end
        default: next_st.tx = TX_IDLE;
      endcase
    end
    if (loaded)
    begin
      next_st.tx_full = 1'b0;
      next_st.txen = 1'b1; // [RULE_14]
      next_st.txer = st.ctrl[`EMII_CB_TXERR]; // [RULE_15]
      if (serial)
      begin
        next_st.txd = {3'h0, st.tx_buf[0]}; // [RULE_09]
        next_st.tx_sh = {1'b0, st.tx_buf[7:1]};
        next_st.tx_cnt = `EMII_SER_LAST;
      end
      else
      begin
        next_st.txd = st.tx_buf[3:0]; // [RULE_13]
        next_st.tx_sh = {4'h0, st.tx_buf[7:4]};
        next_st.tx_cnt = `EMII_MII_LAST;
      end
    end

    // receive: assemble bytes, partial bytes dropped when framing ends
    if (rx_edge)
    begin
      if (!rx_ok)
      begin
        next_st.rx_cnt = 3'h0;
      end
      else
      begin
        if (serial)
        begin
          next_st.rx_sh = {fn[0], st.rx_sh[7:1]}; // [RULE_10]
        end
        else
        begin
          next_st.rx_sh = {fn[3:0], st.rx_sh[7:4]}; // [RULE_18] [RULE_20]
          if (fn[I_RXER])
          begin
            next_st.rx_err = 1'b1; // [RULE_19]
          end
        end
        next_st.rx_cnt = rx_last ? 3'h0 : 3'(st.rx_cnt + 3'h1);
        if (rx_last)
        begin
          next_st.rx_byte = next_st.rx_sh;
          // a new byte over an unread one sets overrun and beats a status-read clear
          if (st.rx_val)
          begin
            next_st.rx_ovr = 1'b1;
          end
          next_st.rx_val = 1'b1;
        end
      end
    end

    // management frame: bits change on mdc fall, sampled on rise
    case (st.mg)
      MG_IDLE: next_st.mdo_en = 1'b0;
      MG_DRIVE:
      begin
        if (mi.fall)
        begin
          if (st.mg_cnt == `EMII_MG_FRAME)
          begin
            next_st.mg = MG_IDLE;
            next_st.mdo_en = 1'b0;
          end
          else if (st.mg_rd && st.mg_cnt == `EMII_MG_RD_DRIVE)
          begin
            next_st.mg = MG_LISTEN;
            next_st.mdo_en = 1'b0; // [RULE_12]
            next_st.mg_cnt = 6'(st.mg_cnt + 6'h01);
          end
          else
          begin
            next_st.mdo = st.mg_sh[31];
            next_st.mg_sh = {st.mg_sh[30:0], 1'b0};
            next_st.mg_cnt = 6'(st.mg_cnt + 6'h01);
          end
        end
      end
      MG_LISTEN:
      begin
        if (mi.rise)
        begin
          next_st.mg_rx = {st.mg_rx[14:0], fn[I_MDIO]}; // [RULE_12]
        end
        if (mi.fall)
        begin
          if (st.mg_cnt == `EMII_MG_FRAME)
          begin
            next_st.mg = MG_IDLE;
          end
          else
          begin
            next_st.mg_cnt = 6'(st.mg_cnt + 6'h01);
          end
        end
      end
      default: next_st.mg = MG_IDLE;
    endcase

    if (st.wr_pend)
    begin
      case (st.wr_addr)
        `EMII_OFS_CTRL: next_st.ctrl = hwdata[15:0]; // [RULE_08] [RULE_21]
        `EMII_OFS_TXDATA:
        begin
          // a byte written while the holder is full is dropped, unless the holder is loaded into the shifter in the same cycle
          if (!st.tx_full || loaded)
          begin
            next_st.tx_buf = hwdata[7:0];
            next_st.tx_full = 1'b1;
          end
        end
        `EMII_OFS_MGTX:
        begin
          if (st.mg == MG_IDLE)
          begin
            next_st.mg = MG_DRIVE;
            next_st.mdo = hwdata[31];
            next_st.mdo_en = 1'b1; // [RULE_12]
            next_st.mg_sh = {hwdata[30:0], 1'b0};
            next_st.mg_cnt = 6'h01;
            next_st.mg_rd = (hwdata[`EMII_MG_OP -: 2] == `EMII_MG_OP_RD);
          end
        end
        default: next_st.ctrl = st.ctrl;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st <= '0;
      st.ctrl <= `EMII_CTRL_RST;
      st.tx <= TX_IDLE;
      st.mg <= MG_IDLE;
    end
    else if (ce)
    begin
      st <= next_st;
    end
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_serial_mdc_pin: assert property (serial |-> mdc == (st.ctrl[1] ^ st.ctrl[2])) // [RULE_01]
    else $error("serial mode mdc pin wrong");
  a_serial_txd_gp: assert property (serial |-> {txd2, txd3} == st.ctrl[5:4]) // [RULE_03]
    else $error("serial mode txd3 txd2 wrong");
  a_txd1_open_col: assert property (serial |-> txd1_oe_n == !st.ctrl[6] && !txd1_out) // [RULE_04]
    else $error("txd1 open collector wrong");
  a_gp_rxdv_status: assert property ((ce && $stable(rxdv))[*6] |-> st.gp[0] == rxdv) // [RULE_07]
    else $error("rxdv status bit does not follow pin");
  a_txen_data_valid: assert property (!txen |-> st.txd == 4'h0) // [RULE_14]
    else $error("transmit data present without enable");
  a_tx_on_txclk: assert property (!serial && ce && $changed(st.txd) |-> $past(tx_edge)) // [RULE_13]
    else $error("transmit nibble changed off txclk");
  a_rx_needs_dv: assert property (!serial && $rose(st.rx_val) |-> $past(fn[I_RXDV])) // [RULE_20]
    else $error("receive byte without data valid");
  a_mdio_listen: assert property (st.mg == MG_LISTEN |-> mdio_oe_n) // [RULE_12]
    else $error("mdio driven while phy answers");
  a_mdc_serial_hold: assert property (serial && !mi.run |-> !mi.mdc) // [RULE_11]
    else $error("mdc generator runs without a frame");
  a_read_one_wait: assert property (take && !hwrite && ce |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");

  c_mii_byte_sent: cover property (!serial && $fell(txen));
  c_serial_byte_rx: cover property (serial && $rose(st.rx_val));
  c_mgmt_read_done: cover property (st.mg == MG_LISTEN ##1 st.mg == MG_IDLE);
  c_rx_overrun: cover property ($rose(st.rx_ovr));
endmodule
`default_nettype wire

// [emii_phy.sv]
// behavioural phy model: mii clocks, receive frames, pulled-up mdio and txd1
`default_nettype none
module emii_phy
(
  input wire logic [5:0] idle_val, // {col, rxer, rxdv, rxd3, rxd2, rxd1}; col and rxer always, the rest outside mii frames
  input wire logic mdio_out, // device mdio value
  input wire logic mdio_oe_n, // device mdio enable, low drives
  output logic mdio_in, // resolved mdio pin
  input wire logic txd1_out, // device txd1 value
  input wire logic txd1_oe_n, // device txd1 enable, low drives
  output logic txd1_in, // resolved txd1 pin
  output logic txclk, // transmit clock
  output logic rxclk, // receive clock, still between frames
  output logic [3:0] rxd, // receive data
  output logic rxer, // receive error
  output logic rxdv, // receive data valid
  output logic crs, // carrier sense
  output logic col // collision
);
  timeunit 1ns;
  timeprecision 100ps;
  logic busy = 1'b0;
  logic ser = 1'b0;
  logic last0 = 1'b0;
  logic [3:0] f_rxd = 4'h0;
  initial rxclk = 1'b0;
  // free running: the device cannot open a transmit frame without it
  initial
  begin
    txclk = 1'b0;
    forever #50 txclk = ~txclk;
  end
  assign mdio_in = !mdio_oe_n ? mdio_out : 1'b1; // pull-up, phy never drives
  assign txd1_in = !txd1_oe_n ? txd1_out : 1'b1;
  assign rxd[3:1] = (busy && !ser) ? f_rxd[3:1] : idle_val[2:0];
  assign rxd[0] = busy ? f_rxd[0] : ~last0;
  assign rxdv = (busy && !ser) ? 1'b1 : idle_val[3];
  assign rxer = idle_val[4];
  assign col = idle_val[5];
  assign crs = busy;
  task automatic unit(input logic [3:0] v);
    begin
      f_rxd = v;
      last0 = v[0];
      #40 rxclk = 1'b1;
      #40 rxclk = 1'b0;
    end
  endtask
  // one byte: serial lsb first on rxd0 framed by crs, else two nibbles framed by rxdv
  task automatic send(input logic s, input logic [7:0] b);
    begin
      ser = s;
      busy = 1'b1;
      if (s)
        for (int i = 0; i < 8; i++)
          unit({3'h0, b[i]});
      else
      begin
        unit(b[3:0]);
        unit(b[7:4]);
      end
      busy = 1'b0;
      #40 rxclk = 1'b1;
      #40 rxclk = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// [tb.sv]
// self-checking bench of the mii pin block against the phy model
`default_nettype none
`include "emii_regs.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_count++; $display("unexpected at %0t got %0h exp %0h", $time, (g), (e)); end end
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, mdc, mdio_in, mdio_out, mdio_oe_n, txclk, txd3, txd2, txd1_in;
  logic txd1_out, txd1_oe_n, txd0, txer, txen, col, crs, rxclk, rxer, rxdv;
  logic [31:0] hrdata;
  logic [3:0] rxd;
  logic [5:0] idle_val = 6'h0;
  logic [31:0] seed = 32'h9;
  logic [31:0] rq_e[$];
  logic [31:0] rq_m[$];
  logic [8:0] tq[$];
  logic rd_ph = 1'b0;
  logic ser = 1'b0;
  logic mdc_chk = 1'b0;
  logic [7:0] tsh = 8'h0;
  logic [31:0] r, c, e;
  logic [7:0] b;
  logic [8:0] tx_e;
  int err_count = 0;
  int n_checks = 0;
  int cycles = 0;
  int tn = 0;
  int mdc_n = 0;
  time t_last = 0;
  emii_pins DUT (.hclk, .hresetn, .ce(1'b1), .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hrdata, .hresp, .mdc, .mdio_in, .mdio_out, .mdio_oe_n,
    .txclk, .txd3, .txd2, .txd1_in, .txd1_out, .txd1_oe_n, .txd0, .txer, .txen, .col, .crs,
    .rxclk, .rxd, .rxer, .rxdv);
  emii_phy phy (.idle_val, .mdio_out, .mdio_oe_n, .mdio_in, .txd1_out, .txd1_oe_n, .txd1_in,
    .txclk, .rxclk, .rxd, .rxer, .rxdv, .crs, .col);
  always #5 hclk = ~hclk;
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic idle(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // ready is read at the falling edge, where it equals what the next rising edge samples
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic chk, output logic [31:0] q);
    logic rdy;
    begin
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      do
      begin
        @(negedge hclk);
        rdy = hreadyout;
        @(posedge hclk);
      end
      while (!rdy);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      rd_ph <= chk & !w;
      do
      begin
        @(negedge hclk);
        rdy = hreadyout;
        q = hrdata;
        @(posedge hclk);
      end
      while (!rdy);
      rd_ph <= 1'b0;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    xfer(1'b1, a, d, 1'b0, x);
  endtask
  task automatic rd_exp(input logic [7:0] a, input logic [31:0] ex, input logic [31:0] m);
    logic [31:0] x;
    begin
      rq_e.push_back(ex);
      rq_m.push_back(m);
      xfer(1'b0, a, 32'h0, 1'b1, x);
    end
  endtask
  task automatic poll(input logic [7:0] a, input int p, input logic v);
    logic [31:0] x;
    int k;
    begin
      k = 0;
      do
      begin
        xfer(1'b0, a, 32'h0, 1'b0, x);
        k++;
      end
      while (x[p] !== v && k < 300);
      `CHK(x[p], v)
    end
  endtask
  task automatic wait_tx();
    int k;
    begin
      idle(20);
      for (k = 0; k < 3000 && txen !== 1'b0; k++)
        @(posedge hclk);
    end
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  task automatic stop_test();
    begin
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  always @(negedge hclk)
    if (rd_ph && hreadyout)
    begin
      `CHK(hrdata & rq_m[0], rq_e[0])
      void'(rq_e.pop_front());
      void'(rq_m.pop_front());
    end
  // phy side view of each transmitted byte
  always @(posedge txclk)
    if (txen)
    begin
      tsh = ser ? {txd0, tsh[7:1]} : {txd3, txd2, txd1_in, txd0, tsh[7:4]};
      tn++;
      if (tn == (ser ? 8 : 2))
      begin
        tx_e = tq.pop_front();
        `CHK({txer, tsh}, tx_e)
        tn = 0;
      end
    end
  always @(posedge mdc)
  begin
    mdc_n++;
    if (mdc_chk && mdc_n > 1)
      `CHK($time - t_last, 64'd120)
    if (mdc_chk && mdc_n == 5)
      `CHK(mdio_oe_n, 1'b0)
    if (mdc_chk && mdc_n == 20)
      `CHK(mdio_oe_n, 1'b1)
    t_last = $time;
  end
  always @(posedge hclk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      err_count++;
      stop_test();
    end
  end
  initial
  begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    `CHK({mdio_oe_n, txen, mdc, hreadyout, hresp}, 5'b10010)
    rd_exp(`EMII_OFS_CTRL, 32'h0, 32'hffff);
    rd_exp(`EMII_OFS_STAT, 32'h1, 32'h7f);
    hsize <= 3'h0;
    wr(`EMII_OFS_CTRL, 32'hffff);
    hsize <= 3'h2;
    wr(8'h24, rnd());
    rd_exp(`EMII_OFS_CTRL, 32'h0, 32'hffff);
    rd_exp(8'h24, 32'h0, 32'hffffffff);
    done("registers");
    wr(`EMII_OFS_CTRL, 32'h2000);
    wr(`EMII_OFS_MGTX, 32'h60000000 | (rnd() & 32'h0fffffff));
    mdc_n = 0;
    mdc_chk = 1'b1;
    idle(40);
    poll(`EMII_OFS_STAT, `EMII_SB_MGBUSY, 1'b0);
    mdc_chk = 1'b0;
    `CHK(mdc_n > 30, 1'b1)
    rd_exp(`EMII_OFS_MGRX, 32'hffff, 32'hffff);
    done("management");
    wr(`EMII_OFS_CTRL, 32'h0100);
    repeat (2)
    begin
      poll(`EMII_OFS_STAT, `EMII_SB_TXRDY, 1'b1);
      b = 8'(rnd());
      tq.push_back({1'b1, b});
      wr(`EMII_OFS_TXDATA, {24'h0, b});
    end
    wait_tx();
    `CHK({txen, txd3, txd2, txd0, txer}, 5'h0)
    done("mii transmit");
    ser = 1'b1;
    wr(`EMII_OFS_CTRL, 32'h0001);
    b = 8'(rnd());
    tq.push_back({1'b0, b});
    wr(`EMII_OFS_TXDATA, {24'h0, b});
    wait_tx();
    `CHK(tq.size(), 0)
    done("serial transmit");
    repeat (4)
    begin
      r = rnd();
      c = {24'h0, r[7:1], 1'b1};
      idle_val <= r[13:8];
      wr(`EMII_OFS_CTRL, c);
      idle(8);
      `CHK(mdc, c[1] ^ c[2])
      `CHK({mdio_oe_n, mdio_in}, {1'b0, c[3]})
      `CHK({txd3, txd2}, {c[4], c[5]})
      `CHK(txd1_in, ~c[6])
      `CHK(txer, c[7])
      e = {16'h0, r[9], ~c[6], r[8], r[10], r[12], r[11], 5'h0, r[13], 4'h0};
      rd_exp(`EMII_OFS_STAT, e, 32'hfc30);
    end
    b = 8'(rnd());
    phy.send(1'b1, b);
    @(posedge hclk);
    idle(10);
    rd_exp(`EMII_OFS_RXDATA, {24'h0, b}, 32'hff);
    done("serial pins and receive");
    // receive error held high so the mii frame must leave the sticky error flag
    idle_val <= 6'h10;
    ser = 1'b0;
    wr(`EMII_OFS_CTRL, 32'h00fe);
    idle(8);
    `CHK({txd3, txd2, txd1_in, txd0, txer, txen, mdio_oe_n}, 7'h01)
    b = 8'(rnd());
    phy.send(1'b0, b);
    @(posedge hclk);
    idle(10);
    rd_exp(`EMII_OFS_STAT, 32'ha, 32'ha);
    rd_exp(`EMII_OFS_RXDATA, {24'h0, b}, 32'hff);
    rd_exp(`EMII_OFS_STAT, 32'h0, 32'h2);
    done("mii receive");
    stop_test();
  end
endmodule
`default_nettype wire
